// *** cmo_can_node.sv ***
// Far-side CAN node seen through a transceiver: wired-AND bus level
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// Bus model
module cmo_can_node (
   input wire logic txPin,
   input wire logic nodeDominant,
   output logic rxPin
);
   // Released bus floats recessive; any dominant driver wins
   assign rxPin = txPin & ~nodeDominant;
endmodule : cmo_can_node

`default_nettype wire

// *** cmo_mode_options.sv ***
// CAN control-register modes: loop-back, sampling, bus-off recovery, listen-only, timing
//
// Design decisions made here: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none

// Function
// - Loop-back feeds the transmit bit stream into the receiver.
// - Loop-back ignores the receive pin and holds transmit pin recessive.
// - Loop-back replaces the acknowledge slot bit with an internal dominant acknowledge.
// - Loop-back frames raise both transmit and receive events.
// - Single-sample mode takes one sample at end of phase segment 1.
// - Triple-sample mode votes over sample point and two preceding quanta.
// - Recovery-disable set keeps the device bus-off until software clears it.
// - Clearing before 128 recessive sequences recovers as if never set.
// - Clearing after 128 sequences waits 11 more recessive bits before rejoining.
// - Setting recovery-disable during bus-off only affects the next bus-off.
// - Timer-sync resets the free-running timer on reception into buffer 0.
// - Transmit-order bit picks lowest identifier or lowest buffer index first.
// - Listen-only blocks transmission, freezes error counters, forces error-passive.
// - Listen-only flags dominant-bit error on unacknowledged frame, receive count untouched.
// - Propagation segment lasts field value plus one time quantum.
// - Serial clock is source clock divided by divider field plus one.
module cmo_mode_options
   import cmo_pkg::*;
#(
   parameter int SEQ_TARGET = CMO_SEQ_TARGET
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [CMO_ADDR_W-1:0] regAddr,
   input wire logic [31:0] regWdata,
   input wire logic regWrite,
   input wire logic regRead,
   output logic [31:0] regRdata,
   input wire logic rxPin,
   output logic txPin,
   input wire logic txBitIn,
   input wire logic ackSlot,
   input wire logic frameTxDone,
   input wire logic frameRxDone,
   input wire logic frameRxMb0,
   input wire logic busOffEntry,
   output logic rxBit,
   output logic rxBitValid,
   output logic quantumTick,
   output logic timerReset,
   output logic txOrderByIndex,
   output logic errCountFreeze,
   output logic errorPassiveForce,
   output logic dominantBitError,
   output logic busOff,
   output logic irq
);

   // ==========================================================
   // Elaboration checks
   if (SEQ_TARGET < 1 || SEQ_TARGET > 255) begin : g_bad_target
      $error("SEQ_TARGET must lie in 1..255");
   end

   // ==========================================================
   // State
   typedef struct packed {
      logic [31:0] ctrl;
      logic [CMO_EVT_W-1:0] status;
      logic [CMO_EVT_W-1:0] mask;
      logic [31:0] rdata;
      logic [CMO_DIV_W-1:0] presCnt;
      logic tick;
      logic [CMO_TQ_W-1:0] tqIdx;
      logic early0;
      logic early1;
      logic rxBit;
      logic rxValid;
      logic txPin;
      logic timerReset;
      logic domErr;
      cmo_busoff_e boState;
      logic busOff;
      logic boLatch;
      logic [3:0] runLen;
      logic [7:0] seqCnt;
      logic irq;
   } cmo_state_s;

   cmo_state_s st_reg;
   cmo_state_s st_next;

   logic [CMO_DIV_W-1:0] divider;
   logic [CMO_TQ_W-1:0] propLen;
   logic [CMO_TQ_W-1:0] samplePt;
   logic [CMO_TQ_W-1:0] bitLast;
   logic rxIn;
   logic sampleNow;
   logic resolved;
   logic loopback_enable;
   logic listen_only_enable;
   logic [CMO_EVT_W-1:0] evt;
   logic [7:0] seqTarget;

   assign seqTarget = 8'(SEQ_TARGET);
   assign divider = st_reg.ctrl[CMO_DIV_LSB +: CMO_DIV_W];
   assign loopback_enable = st_reg.ctrl[CMO_LPB_BIT];
   assign listen_only_enable = st_reg.ctrl[CMO_LOM_BIT];
   // Sync quantum, then propagation, then phase segment 1
   assign propLen = CMO_TQ_W'(st_reg.ctrl[CMO_PROP_LSB +: CMO_SEG_W]) + CMO_ONE_TQ;
   assign samplePt = CMO_TQ_W'(st_reg.ctrl[CMO_PROP_LSB +: CMO_SEG_W])
      + CMO_TQ_W'(st_reg.ctrl[CMO_PSEG1_LSB +: CMO_SEG_W]) + CMO_SAMPLE_BASE;
   assign bitLast = samplePt + CMO_TQ_W'(st_reg.ctrl[CMO_PSEG2_LSB +: CMO_SEG_W])
      + CMO_ONE_TQ;
   // Own transmit stream replaces the pin in loop-back
   assign rxIn = loopback_enable ? txBitIn : rxPin;
   assign sampleNow = st_reg.tick && (st_reg.tqIdx == samplePt);

   always_comb begin
      logic vote;
      vote = (st_reg.early0 & st_reg.early1) | (st_reg.early0 & rxIn)
         | (st_reg.early1 & rxIn);
      if (st_reg.ctrl[CMO_SMP_BIT]) begin
         resolved = vote;
      end else begin
         resolved = rxIn;
      end
      if (loopback_enable && ackSlot) begin
         resolved = CMO_DOMINANT;
      end
   end

   // ==========================================================
   // Next-state logic
   always_comb begin
      st_next = st_reg;
      evt = CMO_EVT_RESET;
      st_next.rdata = 32'h0000_0000;

      // Register port
      if (regWrite) begin
         unique case (regAddr)
            CMO_OFF_CONTROL: st_next.ctrl = regWdata & ~CMO_CTRL_RSVD;
            CMO_OFF_MASK: st_next.mask = regWdata[CMO_EVT_W-1:0];
            default: ;
         endcase
      end
      if (regRead) begin
         unique case (regAddr)
            CMO_OFF_CONTROL: st_next.rdata = st_reg.ctrl;
            CMO_OFF_STATUS: st_next.rdata = {27'h0, st_reg.status};
            CMO_OFF_MASK: st_next.rdata = {27'h0, st_reg.mask};
            CMO_OFF_BUSSTATE: st_next.rdata = {22'h0, st_reg.seqCnt, st_reg.boState};
            default: st_next.rdata = 32'h0000_0000;
         endcase
      end

      // Time quantum from the prescaler
      st_next.tick = 1'b0;
      if (st_reg.presCnt >= divider) begin
         st_next.presCnt = '0;
         st_next.tick = 1'b1;
      end else begin
         st_next.presCnt = st_reg.presCnt + 8'h01;
      end

      // Bit timing and sampling
      st_next.rxValid = 1'b0;
      if (st_reg.tick) begin
         if (st_reg.tqIdx >= bitLast) begin
            st_next.tqIdx = '0;
         end else begin
            st_next.tqIdx = st_reg.tqIdx + CMO_ONE_TQ;
         end
         if (st_reg.tqIdx == samplePt - CMO_SAMPLE_BASE) begin
            st_next.early0 = rxIn;
         end
         if (st_reg.tqIdx == samplePt - CMO_ONE_TQ) begin
            st_next.early1 = rxIn;
         end
      end
      st_next.domErr = 1'b0;
      if (sampleNow) begin
         st_next.rxBit = resolved;
         st_next.rxValid = 1'b1;
         // Nobody acknowledged what we only listened to
         if (listen_only_enable && !loopback_enable && ackSlot && resolved == CMO_RECESSIVE) begin
            st_next.domErr = 1'b1;
            evt[CMO_EVT_BITERR] = 1'b1;
         end
      end

      // Transmit pin; a bus-off node stays off the bus too
      if (loopback_enable || listen_only_enable || st_reg.boState != BO_ACTIVE) begin
         st_next.txPin = CMO_RECESSIVE;
      end else begin
         st_next.txPin = txBitIn;
      end

      st_next.timerReset = st_reg.ctrl[CMO_TIMER_SYNC_ENABLE_BIT] && frameRxMb0;

      // Frame events; own frame counts as received in loop-back
      evt[CMO_EVT_TX] = frameTxDone;
      evt[CMO_EVT_RX] = frameRxDone || (loopback_enable && frameTxDone);

      // Bus-off recovery
      unique case (st_reg.boState)
         BO_ACTIVE: begin
            if (busOffEntry) begin
               st_next.boState = BO_COUNT;
               st_next.boLatch = st_reg.ctrl[CMO_BUSOFF_RECOVERY_DISABLE_BIT];
               st_next.runLen = '0;
               st_next.seqCnt = '0;
               evt[CMO_EVT_BOFF] = 1'b1;
            end
         end
         BO_COUNT: begin
            // Clearing is honoured at once, setting waits for the next entry
            if (!st_reg.ctrl[CMO_BUSOFF_RECOVERY_DISABLE_BIT]) begin
               st_next.boLatch = 1'b0;
            end
            if (sampleNow) begin
               if (resolved == CMO_RECESSIVE) begin
                  st_next.runLen = st_reg.runLen + 4'h1;
                  if (st_reg.runLen + 4'h1 == CMO_RECESSIVE_RUN) begin
                     st_next.runLen = '0;
                     st_next.seqCnt = st_reg.seqCnt + 8'h01;
                     if (st_reg.seqCnt + 8'h01 == seqTarget) begin
                        if (st_reg.boLatch && st_reg.ctrl[CMO_BUSOFF_RECOVERY_DISABLE_BIT]) begin
                           st_next.boState = BO_HOLD;
                        end else begin
                           st_next.boState = BO_ACTIVE;
                           evt[CMO_EVT_REJOIN] = 1'b1;
                        end
                     end
                  end
               end else begin
                  st_next.runLen = '0;
               end
            end
         end
         BO_HOLD: begin
            if (!st_reg.ctrl[CMO_BUSOFF_RECOVERY_DISABLE_BIT]) begin
               st_next.boState = BO_WAIT;
               st_next.runLen = '0;
            end
         end
         BO_WAIT: begin
            if (sampleNow) begin
               if (resolved == CMO_RECESSIVE) begin
                  st_next.runLen = st_reg.runLen + 4'h1;
                  if (st_reg.runLen + 4'h1 == CMO_RECESSIVE_RUN) begin
                     st_next.boState = BO_ACTIVE;
                     st_next.runLen = '0;
                     evt[CMO_EVT_REJOIN] = 1'b1;
                  end
               end else begin
                  st_next.runLen = '0;
               end
            end
         end
      endcase

      // Registered copy so the output is a plain flip-flop, not a state decode
      st_next.busOff = (st_next.boState != BO_ACTIVE);

      // Sticky events: a new event wins over the clearing read
      if (regRead && regAddr == CMO_OFF_STATUS) begin
         st_next.status = evt;
      end else begin
         st_next.status = st_reg.status | evt;
      end
      st_next.irq = |(st_next.status & st_next.mask);
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         st_reg <= '{ctrl: CMO_CTRL_RESET, status: CMO_EVT_RESET, mask: CMO_EVT_RESET,
            rdata: 32'h0000_0000, presCnt: '0, tick: 1'b0, tqIdx: '0,
            early0: CMO_RECESSIVE, early1: CMO_RECESSIVE, rxBit: CMO_RECESSIVE,
            rxValid: 1'b0, txPin: CMO_RECESSIVE, timerReset: 1'b0, domErr: 1'b0,
            boState: BO_ACTIVE, busOff: 1'b0, boLatch: 1'b0, runLen: '0, seqCnt: '0, irq: 1'b0};
      end else begin
         st_reg <= st_next;
      end
   end

   // ==========================================================
   // Outputs
   assign regRdata = st_reg.rdata;
   assign txPin = st_reg.txPin;
   assign rxBit = st_reg.rxBit;
   assign rxBitValid = st_reg.rxValid;
   assign quantumTick = st_reg.tick;
   assign timerReset = st_reg.timerReset;
   assign txOrderByIndex = st_reg.ctrl[CMO_TX_ORDER_BY_INDEX_BIT];
   assign errCountFreeze = st_reg.ctrl[CMO_LOM_BIT];
   assign errorPassiveForce = st_reg.ctrl[CMO_LOM_BIT];
   assign dominantBitError = st_reg.domErr;
   assign busOff = st_reg.busOff;
   assign irq = st_reg.irq;

   // ==========================================================
   // Assertions
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!reset_n);

   chk_lpb_tx_recessive: assert property (loopback_enable |=> txPin)
      else $error("Transmit pin not recessive in loop-back");
   chk_lpb_loop_path: assert property (
      loopback_enable && sampleNow && !ackSlot && !st_reg.ctrl[CMO_SMP_BIT]
      |=> rxBitValid && rxBit == $past(txBitIn))
      else $error("Loop-back receive bit differs from transmit bit");
   chk_lpb_ack_forced: assert property (loopback_enable && sampleNow && ackSlot |=> rxBit == 1'b0)
      else $error("Loop-back acknowledge slot not dominant");
   chk_lpb_both_events: assert property (
      loopback_enable && frameTxDone |=> st_reg.status[CMO_EVT_TX] && st_reg.status[CMO_EVT_RX])
      else $error("Loop-back frame missed an event");
   chk_single_sample: assert property (
      sampleNow && !st_reg.ctrl[CMO_SMP_BIT] && !loopback_enable |=> rxBit == $past(rxPin))
      else $error("Single sample not taken from pin");
   chk_triple_vote: assert property (
      sampleNow && st_reg.ctrl[CMO_SMP_BIT] && !ackSlot
      && st_reg.early0 == st_reg.early1 |=> rxBit == $past(st_reg.early0))
      else $error("Majority vote wrong");
   chk_boff_hold: assert property (
      st_reg.boState == BO_HOLD && st_reg.ctrl[CMO_BUSOFF_RECOVERY_DISABLE_BIT] |=> busOff)
      else $error("Left bus-off while recovery disabled");
   chk_boff_clear_early: assert property (
      st_reg.boState == BO_COUNT && !st_reg.ctrl[CMO_BUSOFF_RECOVERY_DISABLE_BIT] |=> !st_reg.boLatch)
      else $error("Early clear not honoured");
   chk_boff_wait_run: assert property (
      st_reg.boState == BO_HOLD && !st_reg.ctrl[CMO_BUSOFF_RECOVERY_DISABLE_BIT]
      |=> st_reg.boState == BO_WAIT && st_reg.runLen == 4'h0)
      else $error("Late clear did not start recessive wait");
   chk_boff_late_set: assert property (
      st_reg.boState == BO_COUNT && !st_reg.boLatch |=> !st_reg.boLatch)
      else $error("Recovery-disable set took effect mid bus-off");
   chk_timer_sync: assert property (
      st_reg.ctrl[CMO_TIMER_SYNC_ENABLE_BIT] && frameRxMb0
      |=> timerReset)
      else $error("Timer reset missing");
   chk_lom_tx_block: assert property (
      listen_only_enable |-> errCountFreeze && errorPassiveForce ##1 txPin)
      else $error("Listen-only transmitted or counters live");
   chk_lom_ack_error: assert property (
      listen_only_enable && !loopback_enable && sampleNow && ackSlot && resolved |=> dominantBitError)
      else $error("Unacknowledged frame not flagged");
   chk_prop_len: assert property (sampleNow |-> st_reg.tqIdx > propLen)
      else $error("Sample point inside propagation segment");
   chk_quantum_rate: assert property (
      quantumTick && divider != 8'h00 && !regWrite |=> !quantumTick)
      else $error("Quantum tick faster than divider allows");

   // Bus-off entry, timer pulse, listen-only acknowledge and register side
   chk_boff_entry: assert property (
      busOffEntry && !busOff |=> busOff && st_reg.boLatch == $past(st_reg.ctrl[CMO_BUSOFF_RECOVERY_DISABLE_BIT]))
      else $error("Bus-off entry or latched policy wrong");
   chk_boff_tx_quiet: assert property (busOff |=> txPin)
      else $error("Transmit pin driven while bus-off");
   chk_timer_quiet: assert property (!frameRxMb0 |=> !timerReset)
      else $error("Timer reset without buffer 0 reception");
   chk_lom_acked_quiet: assert property (
      listen_only_enable && sampleNow && ackSlot && !resolved |=> !dominantBitError)
      else $error("Acknowledged frame flagged as error");
   chk_rsvd_zero: assert property ((st_reg.ctrl & CMO_CTRL_RSVD) == 32'h0000_0000)
      else $error("Reserved control bits not zero");
   chk_status_sticky: assert property (
      st_reg.status[CMO_EVT_RX] && !(regRead && regAddr == CMO_OFF_STATUS)
      |=> st_reg.status[CMO_EVT_RX])
      else $error("Status bit lost without a read");

   cov_loopback_frame: cover property (loopback_enable && frameTxDone ##1 irq);
   cov_triple_sample: cover property (sampleNow && st_reg.ctrl[CMO_SMP_BIT]);
   cov_busoff_rejoin: cover property (busOff ##1 !busOff);
   cov_busoff_hold: cover property (st_reg.boState == BO_HOLD);
   cov_lom_error: cover property (dominantBitError);

endmodule : cmo_mode_options

`default_nettype wire

// *** cmo_pkg.sv ***
// Constants and types shared by the CAN mode and option block
package cmo_pkg;

   // ==========================================================
   // Register map
   localparam int CMO_ADDR_W = 8;
   localparam logic [7:0] CMO_OFF_CONTROL = 8'h00;
   localparam logic [7:0] CMO_OFF_STATUS = 8'h04;
   localparam logic [7:0] CMO_OFF_MASK = 8'h08;
   localparam logic [7:0] CMO_OFF_BUSSTATE = 8'h0c;

   // ==========================================================
   // Control register fields
   localparam logic [31:0] CMO_CTRL_RESET = 32'h0000_0000;
   localparam logic [31:0] CMO_CTRL_RSVD = 32'h0000_0f00;
   localparam int CMO_DIV_LSB = 24;
   localparam int CMO_DIV_W = 8;
   localparam int CMO_PSEG1_LSB = 19;
   localparam int CMO_PSEG2_LSB = 16;
   localparam int CMO_SEG_W = 3;
   localparam int CMO_LPB_BIT = 12;
   localparam int CMO_SMP_BIT = 7;
   localparam int CMO_BUSOFF_RECOVERY_DISABLE_BIT = 6;
   localparam int CMO_TIMER_SYNC_ENABLE_BIT = 5;
   localparam int CMO_TX_ORDER_BY_INDEX_BIT = 4;
   localparam int CMO_LOM_BIT = 3;
   localparam int CMO_PROP_LSB = 0;

   // ==========================================================
   // Event status and mask layout
   localparam int CMO_EVT_W = 5;
   localparam logic [4:0] CMO_EVT_RESET = 5'h00;
   localparam int CMO_EVT_TX = 0;
   localparam int CMO_EVT_RX = 1;
   localparam int CMO_EVT_BOFF = 2;
   localparam int CMO_EVT_REJOIN = 3;
   localparam int CMO_EVT_BITERR = 4;

   // ==========================================================
   // Bit timing and bus-off recovery
   localparam int CMO_TQ_W = 5;
   localparam logic [4:0] CMO_SAMPLE_BASE = 5'h02;
   localparam logic [4:0] CMO_ONE_TQ = 5'h01;
   localparam logic [3:0] CMO_RECESSIVE_RUN = 4'hb;
   localparam int CMO_SEQ_TARGET = 128;
   localparam logic CMO_RECESSIVE = 1'b1;
   localparam logic CMO_DOMINANT = 1'b0;

   typedef enum logic [1:0] {
      BO_ACTIVE,
      BO_COUNT,
      BO_HOLD,
      BO_WAIT
   } cmo_busoff_e;

endpackage : cmo_pkg

// *** tb.sv ***
// Self-checking bench for the CAN mode and option block
`timescale 1ns/1ps
`default_nettype none

module tb;
   import cmo_pkg::*;
   localparam int TGT = 2;
   localparam logic [19:0] SAMP_CASES = 20'h169de;
   logic clk, reset_n, regWrite, regRead, txBitIn, ackSlot, nodeDom, rxPin, txPin;
   logic rxBit, rxBitValid, quantumTick, timerReset, txOrderByIndex, errCountFreeze;
   logic errorPassiveForce, dominantBitError, busOff, irq;
   logic [3:0] ev, sc;
   logic [7:0] regAddr;
   logic [31:0] regWdata, regRdata, seed, v;
   int bad_count, num_checks, errSeen, e0, d, p1, p2, n, q;

   cmo_mode_options #(.SEQ_TARGET(TGT)) dut (.clk, .reset_n, .regAddr, .regWdata, .regWrite,
      .regRead, .regRdata, .rxPin, .txPin, .txBitIn, .ackSlot, .frameTxDone(ev[0]),
      .frameRxDone(ev[1]), .frameRxMb0(ev[2]), .busOffEntry(ev[3]), .rxBit, .rxBitValid,
      .quantumTick, .timerReset, .txOrderByIndex, .errCountFreeze, .errorPassiveForce,
      .dominantBitError, .busOff, .irq);
   cmo_can_node node (.txPin, .nodeDominant(nodeDom), .rxPin);

   // ==========================================================
   // Helpers
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : rnd

   function automatic logic vote(input logic [3:0] s);
      if (s[3]) return !((s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]));
      return !s[0];
   endfunction : vote

   function automatic logic win(input int k, input int c);
      return k >= c - 3 && k <= c + 3;
   endfunction : win

   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("BAD %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [31:0] dt);
      @(posedge clk);
      regAddr <= a;
      regWdata <= dt;
      regWrite <= 1'b1;
      @(posedge clk);
      regWrite <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string nm);
      @(posedge clk);
      regAddr <= a;
      regRead <= 1'b1;
      @(posedge clk);
      regRead <= 1'b0;
      @(negedge clk);
      chk(nm, exp, regRdata);
   endtask : rd

   task automatic pulse(input int k);
      @(posedge clk);
      ev[k] <= 1'b1;
      @(posedge clk);
      ev <= 4'h0;
   endtask : pulse

   // Bounded wait for n resolved bits
   task automatic bitw(input int nb);
      int t = 0;
      repeat (nb) begin
         @(negedge clk);
         while (rxBitValid !== 1'b1 && t < 20000) begin
            @(negedge clk);
            t++;
         end
      end
      chk("bit wait", 0, 32'(t >= 20000));
   endtask : bitw

   task automatic boff(input logic b0, input int tc, input logic b1, input int lo, input int hi);
      wr(CMO_OFF_CONTROL, {16'h0001, 9'h0, b0, 6'h0});
      pulse(3);
      @(negedge clk);
      chk("bus off entry", 1, busOff);
      for (int i = 1; i <= hi; i++) begin
         if (i == tc) wr(CMO_OFF_CONTROL, {16'h0001, 9'h0, b1, 6'h0});
         bitw(1);
         if (i <= lo) chk("held bus off", 1, busOff);
      end
      chk("rejoined", 0, busOff);
      rd(CMO_OFF_STATUS, 32'h0c, "bus off events");
   endtask : boff

   task automatic wrap_up;
      $display("Checks %0d, mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : wrap_up

   // ==========================================================
   // Clock, monitor, watchdog
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   always @(negedge clk) if (dominantBitError === 1'b1) errSeen++;

   initial begin
      #500000;
      bad_count++;
      wrap_up();
   end

   // ==========================================================
   // Main sequence
   initial begin
      {reset_n, regWrite, regRead, ackSlot, nodeDom, ev, regAddr, regWdata} = '0;
      txBitIn = 1'b1;
      seed = 32'heb3e;
      repeat (4) @(posedge clk);
      chk("reset tx pin", 1, txPin);
      chk("reset irq", 0, {busOff, irq});
      reset_n <= 1'b1;
      for (int i = 0; i < 5; i++) rd(8'(i * 4), 32'h0, "reset register");
      // Random control images; reserved bits must read back zero
      @(posedge clk);
      txBitIn <= 1'b0;
      repeat (8) begin
         v = rnd();
         wr(CMO_OFF_CONTROL, v);
         rd(CMO_OFF_CONTROL, v & ~CMO_CTRL_RSVD, "control");
         chk("tx order", v[4], txOrderByIndex);
         chk("listen flags", {2{v[3]}}, {errCountFreeze, errorPassiveForce});
         if (v[3] | v[12]) chk("tx pin quiet", 1, txPin);
      end
      @(posedge clk);
      txBitIn <= 1'b1;
      // Bit length for every propagation value
      for (int p = 0; p < 8; p++) begin
         d = rnd() % 4;
         p1 = rnd() % 8;
         p2 = 1 + rnd() % 7;
         wr(CMO_OFF_CONTROL, {8'(d), 2'h0, 3'(p1), 3'(p2), 13'h0, 3'(p)});
         bitw(2);
         n = 0;
         q = 0;
         do begin
            @(negedge clk);
            n++;
            if (quantumTick === 1'b1) q++;
         end while (rxBitValid !== 1'b1 && n < 5000);
         chk("bit period", 32'((p + p1 + p2 + 4) * (d + 1)), 32'(n));
         chk("quanta per bit", 32'(p + p1 + p2 + 4), 32'(q));
      end
      // Loop-back with the outside bus held dominant
      wr(CMO_OFF_CONTROL, 32'h0001_1000);
      nodeDom <= 1'b1;
      bitw(2);
      repeat (12) begin
         v = rnd();
         @(posedge clk);
         txBitIn <= v[0];
         ackSlot <= v[1];
         bitw(1);
         chk("loop bit", v[0] & ~v[1], rxBit);
         chk("loop tx pin", 1, txPin);
      end
      @(posedge clk);
      ackSlot <= 1'b0;
      txBitIn <= 1'b1;
      pulse(0);
      repeat (3) @(negedge clk);
      chk("masked irq", 0, irq);
      rd(CMO_OFF_STATUS, 32'h03, "loop events");
      rd(CMO_OFF_STATUS, 32'h00, "status cleared");
      wr(CMO_OFF_MASK, 32'h03);
      pulse(1);
      repeat (2) @(negedge clk);
      chk("irq raised", 1, irq);
      rd(CMO_OFF_STATUS, 32'h02, "rx event");
      @(negedge clk);
      chk("irq cleared", 0, irq);
      wr(CMO_OFF_MASK, 32'h01);
      pulse(1);
      repeat (3) @(negedge clk);
      chk("irq masked", 0, irq);
      rd(CMO_OFF_STATUS, 32'h02, "rx event");
      @(posedge clk);
      nodeDom <= 1'b0;
      // Timer sync on buffer 0 reception, enabled then disabled
      for (int t = 1; t >= 0; t--) begin
         wr(CMO_OFF_CONTROL, 32'h0001_0000 | (32'(t) << 5));
         pulse(2);
         @(negedge clk);
         chk("timer reset", 32'(t), timerReset);
         @(negedge clk);
         chk("timer reset end", 0, timerReset);
      end
      // Single and triple sampling against short dominant windows
      for (int c = 0; c < 5; c++) begin
         sc = SAMP_CASES[c * 4 +: 4];
         wr(CMO_OFF_CONTROL, {8'h07, 2'h0, 3'h2, 3'h1, 8'h0, sc[3], 4'h0, 3'h2});
         bitw(3);
         for (int k = 1; k <= 78; k++) begin
            @(posedge clk);
            nodeDom <= (sc[0] && win(k, 69)) || (sc[1] && win(k, 61)) || (sc[2] && win(k, 53));
         end
         @(negedge clk);
         chk("sampled bit", vote(sc), rxBit);
      end
      // Listen-only: unacknowledged then acknowledged slot
      wr(CMO_OFF_CONTROL, 32'h0001_0008);
      txBitIn <= 1'b0;
      for (int a = 0; a < 2; a++) begin
         bitw(1);
         e0 = errSeen;
         @(posedge clk);
         ackSlot <= 1'b1;
         nodeDom <= a[0];
         bitw(1);
         @(posedge clk);
         ackSlot <= 1'b0;
         nodeDom <= 1'b0;
         repeat (3) @(negedge clk);
         chk("bit error", 32'(a == 0), 32'(errSeen - e0));
         chk("listen tx pin", 1, txPin);
      end
      rd(CMO_OFF_STATUS, 32'h10, "bit error event");
      @(posedge clk);
      txBitIn <= 1'b1;
      // Bus-off recovery policies
      boff(1'b0, 5, 1'b0, 20, 26);
      boff(1'b0, 3, 1'b1, 20, 26);
      boff(1'b1, 30, 1'b0, 39, 44);
      boff(1'b1, 5, 1'b0, 20, 26);
      wrap_up();
   end
endmodule : tb

`default_nettype wire
